// ===== src/charge_ctl_pkg.sv
package charge_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VOLT_REQ = 8'h00; // Requested charging voltage, mV.
  localparam logic [7:0] ADDR_CURR_REQ = 8'h04; // Requested charging current, mA.
  localparam logic [7:0] ADDR_OPTION = 8'h08; // Option bits.
  localparam logic [7:0] ADDR_STATUS = 8'h0C; // Status word, read only.
  localparam logic [7:0] ADDR_VDAC = 8'h10; // Voltage DAC code, read only.
  localparam logic [7:0] ADDR_BATT = 8'h14; // Battery events, write only.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPT_PULSED_DISABLE_BIT = 0; // Pulsed mode never entered.
  localparam int BATT_INSERT_BIT = 0; // Pulse: new battery inserted.
  localparam int ST_VOLT_CLAMPED_BIT = 0; // Voltage request clamped.
  localparam int ST_POWER_FAIL_BIT = 1; // Input power not qualified.
  localparam int ST_MAINS_BIT = 2; // Adapter detected.
  localparam int ST_PULSED_BIT = 3; // Pulsed low-current mode active.
  localparam int ST_WAKEUP_BIT = 4; // Wake-up charging active.
  localparam int ST_CONTROLLED_BIT = 5; // Controlled charging active.
  localparam int ST_IRANGE_LSB = 8; // Current-limit range code.
  localparam int ST_VRANGE_LSB = 12; // Voltage-limit range code.

  // ----------------------------------------------------------------
  // Electrical figures
  // ----------------------------------------------------------------
  localparam logic [15:0] VREF_MV = 16'd1184; // Reference offset, mV.
  localparam logic [15:0] VFLOOR_MV = 16'd2900; // Bottom of every voltage range.
  localparam logic [15:0] VSTEP_MV = 16'd16; // Voltage granularity.
  localparam logic [15:0] WAKE_MA = 16'd80; // Wake-up current.
  localparam logic [3:0] PULSE_PERIOD = 4'd8; // Pulse train period, cycles.
  localparam logic [3:0] PULSE_HIGH = 4'd1; // One-eighth duty.
  localparam int CLK_HZ = 10_000_000; // mclk rate.
  localparam int SLOW_BIT_MS = 45; // Slow modulator rate per bit.
  localparam int SLOW_BIT_CYCLES = SLOW_BIT_MS * (CLK_HZ / 1000);
  localparam logic [2:0] VOLT_RANGE_TOP = 3'd4; // Highest voltage range code.

  // Current ranges: short, 10k, 33k, open.
  typedef enum logic [1:0] {I_1023, I_2046, I_3068, I_4092} irange_type;

  // Full scale per current range, mA.
  localparam logic [15:0] IFS_MA [4] = '{16'd1023, 16'd2046, 16'd3068, 16'd4092};
  // Ceiling per voltage range, mV.
  localparam logic [15:0] VMAX_MV [5] =
    '{16'd8800, 16'd13104, 16'd17408, 16'd21712, 16'd28000};

  // Comparator bundle from the analog side.
  typedef struct packed {
    logic [2:0] current_limit_range_band; // One-hot band hits above short.
    logic current_limit_range_short; // Pin below lowest band.
    logic [3:0] vlim_band; // One-hot band hits above short.
    logic vlim_short; // Pin below lowest band.
    logic in_above_130; // Adapter input 130 mV over sense node.
    logic in_above_25; // Adapter input over sense node by 25 mV.
    logic in_above_neg25; // Adapter input above sense node less 25 mV.
    logic mains_high; // Adapter sense above threshold.
    logic mains_low; // Adapter sense below threshold less hysteresis.
  } comp_type;

  // Drive bundle towards the analog side.
  typedef struct packed {
    logic [15:0] vdac_code; // Voltage DAC code.
    logic idac_bit; // Current DAC output.
    logic fet_slow_off; // Input FET turned off slowly.
    logic fet_fast_off; // Input FET turned off quickly.
    logic charge_on; // Charging enabled.
  } drive_type;

endpackage

// ===== src/delta_sigma.sv
`timescale 1ns/1ns

// First-order modulator: bit density equals value / full_scale.
module delta_sigma
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic step, // Advance one bit.
  input wire logic [15:0] value, // Numerator, already saturated.
  input wire logic [15:0] full_scale, // Denominator.
  output logic bit_q // Output bit, from a register.
);

  logic [16:0] acc_q; // Running error, below full_scale.
  logic [17:0] sum; // Error plus value.

  assign sum = {1'b0, acc_q} + {2'b00, value};

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Reaching or passing full scale emits a one and removes full scale.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q <= '0;
      bit_q <= 1'b0;
    end
    else if (step)
    begin
      if (sum >= {2'b00, full_scale})
      begin
        acc_q <= 17'(sum - {2'b00, full_scale});
        bit_q <= 1'b1;
      end
      else
      begin
        acc_q <= sum[16:0];
        bit_q <= 1'b0;
      end
    end
  end

endmodule // delta_sigma

// ===== src/charge_limit_dac_control.sv
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns

// Overview of operation
// R1: Four current ranges from limit-pin decode.
// R2: Current range caps current regardless of software.
// R3: Five voltage ranges, 2900 mV floor, 16 mV.
// R4: Voltage range caps voltage regardless of software.
// R5: Voltage code equals request minus reference.
// R6: Request below reference programs zero.
// R7: Over ceiling programs ceiling, sets clamp flag.
// R8: Delta-sigma density equals request over full scale.
// R9: Below one sixteenth enters pulsed mode.
// R10: Pulsed mode gates one-eighth duty train.
// R11: Pulsed mode steps modulator every 45 ms.
// R12: Disable option bit forbids pulsed mode.
// R13: Wake-up forces 80 mA equivalent.
// R14: Power qualification on enable pin and flag.
// R15: Enable low until input 130 mV above.
// R16: Under 25 mV slow off; under -25 fast.
// R17: Mains pin and flag follow hysteretic comparator.
// R18: Wake-up when new battery skips either write.
// R19: Partner writes nonzero voltage and current.
// R20: Range codes latched; gaps fall to lowest.
// R21: Requests at full scale saturate density.
module charge_limit_dac_control
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire charge_ctl_pkg::comp_type comp, // Analog comparator outputs.
  output charge_ctl_pkg::drive_type drive, // Analog drive.
  output logic charger_enable_pin, // Charger enable pin.
  output logic mains_detected_pin, // Adapter detected pin.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] volt_req_q; // Requested voltage, mV.
  logic [15:0] curr_req_q; // Requested current, mA.
  logic pulsed_mode_disable_q; // Option bit.
  logic volt_written_q; // Voltage written since insertion.
  logic curr_written_q; // Current written since insertion.
  logic wakeup_q; // Wake-up charging active.
  charge_ctl_pkg::irange_type irange_q; // Latched current range.
  logic [2:0] vrange_q; // Latched voltage range.
  logic mains_q; // Mains detected flag.
  logic qualified_q; // Input power qualified.
  logic fast_off_q; // Fast turn-off latched.
  logic volt_clamped_q; // Voltage clamp flag.
  logic [15:0] vdac_q; // Voltage DAC code.
  logic pulsed_q; // Pulsed low-current mode active.
  logic [3:0] pulse_cnt_q; // Pulse train phase.
  logic [22:0] slow_cnt_q; // Slow bit divider.
  logic slow_step; // Slow rate enable.
  logic ds_step; // Modulator advance.
  logic ds_bit; // Modulator output.
  logic idac_out; // Current DAC output after train gating.
  logic slow_off; // Slow input FET turn-off.
  logic charge_on; // Charging permitted.
  logic [15:0] ifs; // Selected full scale, mA.
  logic [15:0] vmax; // Selected ceiling, mV.
  logic [15:0] ds_value; // Modulator numerator.
  logic [15:0] vtarget; // Voltage after clamping.
  logic want_pulsed; // Pulsed mode wanted.
  logic controlled; // Controlled charging permitted.
  logic aw_hold_q; // Write address captured.
  logic w_hold_q; // Write data captured.
  logic [7:0] awaddr_q; // Captured write address.
  logic [31:0] wdata_q; // Captured write data.
  logic [3:0] wstrb_q; // Captured strobes.
  logic do_write; // Write commits this cycle.
  logic battery_insert; // Insertion event.
  logic [31:0] rdata_d; // Read mux.
  logic [1:0] rresp_d; // Read answer.

  localparam logic [22:0] SLOW_LAST = 23'(charge_ctl_pkg::SLOW_BIT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Limit range latches
  // ----------------------------------------------------------------
  // Codes settle from the comparators; an in-between level falls back low.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irange_q <= charge_ctl_pkg::I_1023;
      vrange_q <= 3'd0;
    end
    else
    begin
      if (comp.current_limit_range_band[2]) // R1 R20
        irange_q <= charge_ctl_pkg::I_4092;
      else if (comp.current_limit_range_band[1])
        irange_q <= charge_ctl_pkg::I_3068;
      else if (comp.current_limit_range_band[0])
        irange_q <= charge_ctl_pkg::I_2046;
      else
        irange_q <= charge_ctl_pkg::I_1023;
      if (comp.vlim_band[3]) // R3 R20
        vrange_q <= charge_ctl_pkg::VOLT_RANGE_TOP;
      else if (comp.vlim_band[2])
        vrange_q <= 3'd3;
      else if (comp.vlim_band[1])
        vrange_q <= 3'd2;
      else if (comp.vlim_band[0])
        vrange_q <= 3'd1;
      else
        vrange_q <= 3'd0;
    end
  end

  assign ifs = charge_ctl_pkg::IFS_MA[irange_q]; // R1
  assign vmax = charge_ctl_pkg::VMAX_MV[vrange_q]; // R3

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Address and data are caught independently, in either order.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped addresses are acknowledged with a slave error.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      s_axi_bresp <= 2'b00;
    else if (do_write)
      s_axi_bresp <= (awaddr_q == charge_ctl_pkg::ADDR_VOLT_REQ ||
                      awaddr_q == charge_ctl_pkg::ADDR_CURR_REQ ||
                      awaddr_q == charge_ctl_pkg::ADDR_OPTION ||
                      awaddr_q == charge_ctl_pkg::ADDR_BATT) ? 2'b00 : 2'b10;
  end

  assign battery_insert = do_write && awaddr_q == charge_ctl_pkg::ADDR_BATT &&
                          wstrb_q[0] && wdata_q[charge_ctl_pkg::BATT_INSERT_BIT];

  // ----------------------------------------------------------------
  // Request registers
  // ----------------------------------------------------------------
  // Requests are stored raw; limits apply downstream so they cannot be bypassed.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      volt_req_q <= '0;
      curr_req_q <= '0;
      pulsed_mode_disable_q <= 1'b0;
    end
    else if (do_write)
    begin
      if (awaddr_q == charge_ctl_pkg::ADDR_VOLT_REQ)
      begin
        if (wstrb_q[0]) volt_req_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) volt_req_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == charge_ctl_pkg::ADDR_CURR_REQ)
      begin
        if (wstrb_q[0]) curr_req_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) curr_req_q[15:8] <= wdata_q[15:8];
      end
      if (awaddr_q == charge_ctl_pkg::ADDR_OPTION && wstrb_q[0])
        pulsed_mode_disable_q <= wdata_q[charge_ctl_pkg::OPT_PULSED_DISABLE_BIT]; // R12
    end
  end

  // ----------------------------------------------------------------
  // Wake-up tracking
  // ----------------------------------------------------------------
  // Insertion arms wake-up; writing both requests ends it.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      volt_written_q <= 1'b0;
      curr_written_q <= 1'b0;
      wakeup_q <= 1'b0;
    end
    else if (battery_insert)
    begin
      volt_written_q <= 1'b0;
      curr_written_q <= 1'b0;
      wakeup_q <= 1'b1; // R18
    end
    else
    begin
      if (do_write && awaddr_q == charge_ctl_pkg::ADDR_VOLT_REQ)
        volt_written_q <= 1'b1;
      if (do_write && awaddr_q == charge_ctl_pkg::ADDR_CURR_REQ)
        curr_written_q <= 1'b1;
      if (volt_written_q && curr_written_q)
        wakeup_q <= 1'b0; // R18
    end
  end

  // Controlled charging needs both requests nonzero from the partner.
  assign controlled = !wakeup_q && volt_req_q != '0 && curr_req_q != '0; // R19

  // ----------------------------------------------------------------
  // Input power qualification and mains detect
  // ----------------------------------------------------------------
  // Qualification is hysteretic: 130 mV to arm, below -25 mV to drop.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      qualified_q <= 1'b0;
      fast_off_q <= 1'b0;
      mains_q <= 1'b0;
    end
    else
    begin
      if (!comp.in_above_neg25)
      begin
        qualified_q <= 1'b0; // R16
        fast_off_q <= 1'b1; // R16
      end
      else if (comp.in_above_130)
      begin
        qualified_q <= 1'b1; // R15
        fast_off_q <= 1'b0;
      end
      if (comp.mains_high)
        mains_q <= 1'b1; // R17
      else if (comp.mains_low)
        mains_q <= 1'b0; // R17
    end
  end

  assign charger_enable_pin = qualified_q; // R14 R15
  assign mains_detected_pin = mains_q; // R17
  assign slow_off = !fast_off_q && !comp.in_above_25; // R16
  assign charge_on = qualified_q && mains_q && (wakeup_q || controlled); // R15

  // ----------------------------------------------------------------
  // Voltage DAC
  // ----------------------------------------------------------------
  // Clamp to the range ceiling in hardware, then remove the reference.
  always_comb
  begin
    vtarget = volt_req_q;
    if (volt_req_q > vmax)
      vtarget = vmax; // R4 R7
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vdac_q <= '0;
      volt_clamped_q <= 1'b0;
    end
    else
    begin
      volt_clamped_q <= volt_req_q > vmax; // R7
      if (volt_req_q < charge_ctl_pkg::VREF_MV)
        vdac_q <= '0; // R6
      else
        vdac_q <= vtarget - charge_ctl_pkg::VREF_MV; // R5
    end
  end

  // ----------------------------------------------------------------
  // Current DAC
  // ----------------------------------------------------------------
  // Wake-up overrides; otherwise saturate at full scale.
  always_comb
  begin
    if (wakeup_q)
      ds_value = charge_ctl_pkg::WAKE_MA; // R13
    else if (curr_req_q >= ifs)
      ds_value = ifs; // R2 R21
    else
      ds_value = curr_req_q; // R8
  end

  // Pulsed mode below one sixteenth, unless disabled or in wake-up.
  assign want_pulsed = !pulsed_mode_disable_q && !wakeup_q &&
                       {curr_req_q, 4'h0} < {4'h0, ifs}; // R9 R12

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pulsed_q <= 1'b0;
    else
      pulsed_q <= want_pulsed; // R9
  end

  // Slow divider gives the pulsed-mode bit period.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      slow_cnt_q <= '0;
    else if (!pulsed_q || slow_cnt_q == SLOW_LAST)
      slow_cnt_q <= '0;
    else
      slow_cnt_q <= slow_cnt_q + 23'd1;
  end

  assign slow_step = pulsed_q && slow_cnt_q == SLOW_LAST; // R11

  // In pulsed mode the numerator is scaled by eight, since peak is one eighth.
  assign ds_step = pulsed_q ? slow_step : 1'b1; // R11

  // High-frequency train phase, one-eighth duty.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt_q <= '0;
    else if (pulse_cnt_q == charge_ctl_pkg::PULSE_PERIOD - 4'd1)
      pulse_cnt_q <= '0;
    else
      pulse_cnt_q <= pulse_cnt_q + 4'd1;
  end

  delta_sigma u_mod
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .step(ds_step),
    .value(pulsed_q ? {ds_value[12:0], 3'b000} : ds_value),
    .full_scale(ifs),
    .bit_q(ds_bit)
  );

  // Bitstream gates the train in pulsed mode.
  assign idac_out = pulsed_q ? (ds_bit && pulse_cnt_q < charge_ctl_pkg::PULSE_HIGH)
                             : ds_bit; // R10

  // A single assignment drives the whole bundle, so no field has two drivers.
  assign drive = '{vdac_code: vdac_q, idac_bit: idac_out, fet_slow_off: slow_off,
                   fet_fast_off: fast_off_q, charge_on: charge_on}; // R16

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    rresp_d = 2'b00;
    unique case (s_axi_araddr)
      charge_ctl_pkg::ADDR_VOLT_REQ: rdata_d[15:0] = volt_req_q;
      charge_ctl_pkg::ADDR_CURR_REQ: rdata_d[15:0] = curr_req_q;
      charge_ctl_pkg::ADDR_OPTION:
        rdata_d[charge_ctl_pkg::OPT_PULSED_DISABLE_BIT] = pulsed_mode_disable_q;
      charge_ctl_pkg::ADDR_STATUS:
      begin
        rdata_d[charge_ctl_pkg::ST_VOLT_CLAMPED_BIT] = volt_clamped_q; // R7
        rdata_d[charge_ctl_pkg::ST_POWER_FAIL_BIT] = !qualified_q; // R14
        rdata_d[charge_ctl_pkg::ST_MAINS_BIT] = mains_q; // R17
        rdata_d[charge_ctl_pkg::ST_PULSED_BIT] = pulsed_q;
        rdata_d[charge_ctl_pkg::ST_WAKEUP_BIT] = wakeup_q;
        rdata_d[charge_ctl_pkg::ST_CONTROLLED_BIT] = controlled;
        rdata_d[charge_ctl_pkg::ST_IRANGE_LSB +: 2] = irange_q;
        rdata_d[charge_ctl_pkg::ST_VRANGE_LSB +: 3] = vrange_q;
      end
      charge_ctl_pkg::ADDR_VDAC: rdata_d[15:0] = vdac_q;
      default: rresp_d = 2'b10;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read answers one cycle after the address is taken.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence fast_trip_s;
    !comp.in_above_neg25;
  endsequence

  enable_drop_a: assert property (@(posedge mclk) disable iff (!reset_n) // R16
    fast_trip_s |=> !charger_enable_pin && drive.fet_fast_off)
    else $error("Enable not dropped after reverse input.");
  enable_arm_a: assert property (@(posedge mclk) disable iff (!reset_n) // R15
    $rose(charger_enable_pin) |-> $past(comp.in_above_130))
    else $error("Enable rose without 130 mV margin.");
  vdac_cap_a: assert property (@(posedge mclk) disable iff (!reset_n) // R4
    ##1 vdac_q <= vmax - charge_ctl_pkg::VREF_MV || $past(volt_req_q) < vmax)
    else $error("Voltage code above ceiling.");
  vdac_zero_a: assert property (@(posedge mclk) disable iff (!reset_n) // R6
    volt_req_q < charge_ctl_pkg::VREF_MV |=> vdac_q == 16'h0000)
    else $error("Voltage code not zero below reference.");
  clamp_flag_a: assert property (@(posedge mclk) disable iff (!reset_n) // R7
    volt_req_q > vmax |=> volt_clamped_q)
    else $error("Clamp flag missing.");
  wake_value_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
    wakeup_q |-> ds_value == charge_ctl_pkg::WAKE_MA)
    else $error("Wake-up current not forced.");
  no_pulsed_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12
    pulsed_mode_disable_q && $past(pulsed_mode_disable_q) |-> !pulsed_q)
    else $error("Pulsed mode entered while disabled.");
  duty_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
    pulsed_q && drive.idac_bit ##1 pulsed_q |-> !drive.idac_bit)
    else $error("Pulse train wider than one eighth.");
  mains_pin_a: assert property (@(posedge mclk) disable iff (!reset_n) // R17
    comp.mains_high |=> mains_detected_pin)
    else $error("Mains pin not raised.");

endmodule // charge_limit_dac_control

// ===== bench/analog_front.sv
`timescale 1ns/1ns

// Ideal comparators standing in for the analog side; band hits are one-hot above short.
module analog_front
(
  input wire logic signed [15:0] diff_mv,
  input wire logic ac_on,
  input wire logic [1:0] irange,
  input wire logic [2:0] vrange,
  output charge_ctl_pkg::comp_type comp
);
  // Mains high and low are exact opposites, so no hysteresis band is modelled.
  assign comp = {3'((4'h1 << irange) >> 1), irange == 2'h0, 4'((5'h01 << vrange) >> 1),
    vrange == 3'h0, diff_mv >= 16'sh0082, diff_mv >= 16'sh0019, diff_mv >= -16'sh0019,
    ac_on, !ac_on};
endmodule // analog_front

// ===== bench/charge_limit_dac_control_tb.sv
`timescale 1ns/1ns

module charge_limit_dac_control_tb;
  logic mclk = 1'b0, reset_n = 1'b0, ac_on = 1'b0, rdy = 1'b0;
  logic signed [15:0] diff_mv = 16'sh0000;
  logic [1:0] irange = 2'h0, r, s_axi_bresp, s_axi_rresp;
  logic [2:0] vrange = 3'h0;
  logic [4:0] p;
  logic [7:0] addr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic charger_enable_pin, mains_detected_pin, s_axi_awready, s_axi_wready;
  logic s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  charge_ctl_pkg::comp_type comp;
  charge_ctl_pkg::drive_type drive;
  int error_cnt = 0, cmp_count = 0, k;
  analog_front model (.diff_mv, .ac_on, .irange, .vrange, .comp);
  charge_limit_dac_control DUT (.mclk, .reset_n, .comp, .drive, .charger_enable_pin,
    .mains_detected_pin, .s_axi_awaddr(addr), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(rdy), .s_axi_araddr(addr), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rdy));
  always #50 mclk = ~mclk;
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are sampled at the falling edge, where they are settled.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
    logic aw, w, ar, b;
    {aw, w, ar, b} = {wr, wr, !wr, 1'b0};
    addr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {aw, w, ar};
    rdy <= 1'b1;
    for (int n = 0; n < 60 && !b; n++)
    begin
      @(negedge mclk);
      {aw, w, ar} = {aw, w, ar} & ~{s_axi_awready, s_axi_wready, s_axi_arready};
      {b, r} = wr ? {s_axi_bvalid, s_axi_bresp} : {s_axi_rvalid, s_axi_rresp};
      d = s_axi_rdata;
      p = {drive.charge_on, charger_enable_pin, mains_detected_pin, drive.fet_slow_off,
        drive.fet_fast_off};
      @(posedge mclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {aw, w, ar};
    end
    rdy <= 1'b0;
    // Let an edge pass so that a following call never reassigns a handshake in this step.
    @(posedge mclk);
    chk(b, 1'b1);
    if (!b)
      summarize();
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    repeat (2) @(posedge mclk);
    xfer(0, 8'h0C, 0);
    chk(d & m, e);
  endtask
  task automatic ones(input int len);
    k = 0;
    repeat (4) @(posedge mclk);
    repeat (len) @(negedge mclk) k += drive.idac_bit;
    @(posedge mclk);
  endtask
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      irange <= 2'(i);
      vrange <= 3'(i);
      reset_n <= 1'b0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      xfer(1, 8'h00, 32'h7530);
      st(32'h7301, {3'(i), 2'b00, 2'(i), 8'h01});
      xfer(0, 8'h10, 0);
      chk(d, 32'(charge_ctl_pkg::VMAX_MV[i] - charge_ctl_pkg::VREF_MV));
    end
    xfer(1, 8'h00, 32'h1388);
    st(32'h1, 0);
    xfer(0, 8'h10, 0);
    chk(d, 32'(16'h1388 - charge_ctl_pkg::VREF_MV));
    chk(32'(drive.vdac_code), 32'(16'h1388 - charge_ctl_pkg::VREF_MV));
    xfer(1, 8'h00, 32'h03E8);
    xfer(0, 8'h10, 0);
    chk(d, 0);
    $display("test voltage done");
    xfer(1, 8'h04, 32'h01FF);
    ones(1023);
    chk(k >= 510 && k <= 512, 1);
    xfer(1, 8'h04, 32'h07D0);
    ones(64);
    chk(k, 64);
    xfer(1, 8'h04, 32'h003F);
    st(32'h8, 32'h8);
    ones(64);
    chk(k == 0 || k == 8, 1);
    xfer(1, 8'h08, 1);
    st(32'h8, 0);
    xfer(1, 8'h08, 0);
    $display("test current done");
    ac_on <= 1'b1;
    xfer(1, 8'h14, 1);
    st(32'h3C, 32'h14);
    chk(p[2], 1);
    ones(1023);
    chk(k >= 79 && k <= 81, 1);
    xfer(1, 8'h00, 32'h1388);
    xfer(1, 8'h04, 32'h01F4);
    st(32'h3C, 32'h24);
    ac_on <= 1'b0;
    st(32'h4, 0);
    chk(p[2], 0);
    diff_mv <= 16'sh0064;
    st(32'h2, 32'h2);
    diff_mv <= 16'sh00C8;
    st(32'h2, 0);
    chk(p, 4'h8);
    diff_mv <= 16'sh000A;
    st(32'h2, 0);
    chk(p, 4'hA);
    diff_mv <= -16'sh001E;
    st(32'h2, 32'h2);
    chk(p & 4'h9, 4'h1);
    diff_mv <= 16'sh0064;
    st(32'h2, 32'h2);
    ac_on <= 1'b1;
    diff_mv <= 16'sh00C8;
    st(32'h26, 32'h24);
    chk(p[4], 1);
    $display("test power done");
    xfer(0, 8'h14, 0);
    chk(r, 2'h2);
    xfer(1, 8'h0C, 0);
    chk(r, 2'h2);
    summarize();
  end
endmodule // charge_limit_dac_control_tb
